// ==== pms_pkg.sv ====
// Shared constants and types for the management strap and control block
package pms_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int SOFT_RST_NS = 1000;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SOFT_RST_LOAD = 8'(SOFT_RST_CYC - 1);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ==========================================================
  // Register addresses (direct space 0x00..0x1f, indirect 16 bit)
  localparam logic [15:0] REG_BASIC_CTRL = 16'h0000;
  localparam logic [15:0] REG_BASIC_STAT = 16'h0001;
  localparam logic [15:0] REG_EXT_CTRL = 16'h000d;
  localparam logic [15:0] REG_EXT_DATA = 16'h000e;
  localparam logic [15:0] REG_STRAP_STAT = 16'h0010;
  localparam logic [15:0] REG_LINK_CTRL = 16'h0011;
  localparam logic [15:0] REG_LED_SEL = 16'h0460;
  localparam logic [4:0] DEV_VENDOR = 5'h1f;
  localparam logic [4:0] DEV_PMA = 5'h01;

  // ==========================================================
  // Field positions and fixed values
  localparam int CTRL_RST = 15;
  localparam int CTRL_LOOP = 14;
  localparam int CTRL_PD = 11;
  localparam int CTRL_ISO = 10;
  localparam logic CTRL_SPEED_VAL = 1'h1;
  localparam logic CTRL_ANEG_VAL = 1'h0;
  localparam logic [9:0] CTRL_RSVD = 10'h100;
  localparam logic [15:0] STAT_FIXED = 16'h0061;
  localparam int EXT_FN_MSB = 15;
  localparam logic [1:0] EXT_FN_ADDR = 2'h0;
  localparam int LED_STRIDE = 4;
  localparam int LED_CLK_SEL = 12;
  localparam logic [15:0] LED_SEL_RESET = 16'h0010;
  localparam logic [1:0] LED_FN_LINK = 2'h0;
  localparam logic [1:0] LED_FN_ACT = 2'h1;
  localparam logic [1:0] LED_FN_ON = 2'h2;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam int MEM_WORDS = 16;

  // ==========================================================
  // Frame receiver states
  typedef enum logic [2:0] {
    MS_IDLE, MS_START, MS_OP, MS_PHY, MS_REG, MS_TA, MS_DATA
  } pms_frame_st_t;

endpackage : pms_pkg

// ==== pms_mem_if.sv ====
// Bundle between the control block and its extended scratch memory
interface pms_mem_if;
  logic we;
  logic [3:0] waddr;
  logic [15:0] wdata;
  logic [3:0] raddr;
  logic [15:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface : pms_mem_if

// ==== pms_ext_mem.sv ====
// Small word memory backing the second extended register space
module pms_ext_mem (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  pms_mem_if.mem port
);
  typedef struct packed {
    logic [pms_pkg::MEM_WORDS-1:0][15:0] words;
    logic [15:0] rdata;
  } pms_mem_state_t;

  pms_mem_state_t s;
  pms_mem_state_t next_s;

  // ==========================================================
  // Write port and registered read port
  always_comb begin
    next_s = s;
    if (port.we) begin
      next_s.words[port.waddr] = port.wdata;
    end
    next_s.rdata = s.words[port.raddr];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign port.rdata = s.rdata;
endmodule : pms_ext_mem

// ==== pms_top.sv ====
// Management frame slave, strap latch and basic control registers
// Functional notes
// RL1: Four strap pins give address 0..15
// RL2: Strap address latched only at reset release
// RL3: No pull-ups means address zero
// RL4: Auto strap 0 links alone, 1 waits
// RL5: LED drive polarity follows sampled strap level
// RL6: Three LEDs, function chosen by 0x460
// RL7: Direct access covers registers 0x0..0x1F only
// RL8: Higher registers only through indirect window
// RL9: Indirect sequence via registers 0xD and 0xE
// RL10: Device 11111 vendor, 00001 second space
// RL11: Vendor indirect 0x0..0x1F mirrors direct registers
// RL12: Bit 15 soft reset, self clears
// RL13: Bit 14 loopback, no link indication
// RL14: Bit 13 reads one, bit 12 zero
// RL15: Bit 11 power down, pin sets it
// RL16: Bit 10 isolates MAC data interface
// RL17: Latched status holds until read, then clears
// RL18: Self clearing field drops when event ends
// RL19: Strap fields default from bootstrap pins
// RL20: Each PHY on bus needs unique address
// RL21: Answer only frames carrying own address
// RL22: Bits 9..0 read fixed, writes ignored
module pms_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [3:0] mgmt_addr_strap,
  input wire logic irq_or_powerdown_pin_n,
  input wire logic link_up,
  input wire logic activity,
  input wire logic jabber,
  input wire logic remote_fault,
  input wire logic indicator_a_in,
  output logic indicator_out_a,
  output logic indicator_a_oe,
  input wire logic indicator_b_in,
  output logic indicator_out_b,
  output logic indicator_b_oe,
  input wire logic indicator_c_in,
  output logic indicator_out_c,
  output logic indicator_c_oe,
  output logic pcs_reset,
  output logic mac_loopback,
  output logic power_down,
  output logic isolate,
  output logic link_enable,
  output logic link_indication
);

  // ==========================================================
  // State
  typedef struct packed {
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    logic pd_s1;
    logic pd_s2;
    logic [2:0] led_s1;
    logic [2:0] led_s2;
    logic [3:0] adr_s1;
    logic [3:0] adr_s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [3:0] phy_addr;
    logic auto_strap;
    logic [2:0] led_pol;
    pms_pkg::pms_frame_st_t st;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [1:0] op;
    logic [4:0] regad;
    logic hit;
    logic mdio_out;
    logic mdio_oe;
    logic loopback;
    logic pd;
    logic iso;
    logic rst_busy;
    logic [7:0] rst_cnt;
    logic link_ll;
    logic jab_lh;
    logic rf_lh;
    logic [15:0] ext_ctrl;
    logic [15:0] ext_addr;
    logic [15:0] led_sel;
    logic link_start;
    logic [2:0] led_out;
    logic clk_div;
    logic link_ind;
    logic link_en;
    logic mem_we;
    logic [3:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [3:0] mem_raddr;
  } pms_state_t;

  pms_state_t s;
  pms_state_t next_s;
  pms_mem_if mem_bus ();

  pms_ext_mem u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .port(mem_bus.mem)
  );

  assign mem_bus.we = s.mem_we;
  assign mem_bus.waddr = s.mem_waddr;
  assign mem_bus.wdata = s.mem_wdata;
  assign mem_bus.raddr = s.mem_raddr;

  // ==========================================================
  // Decode helpers, shared by the direct and indirect paths
  function automatic logic hits(input logic [4:0] dev,
                                input logic [15:0] adr,
                                input logic [4:0] want_dev,
                                input logic [15:0] want_adr);
    hits = (dev == want_dev) && (adr == want_adr);
  endfunction : hits

  function automatic logic [15:0] read_reg(input logic [4:0] dev,
                                           input logic [15:0] adr,
                                           input pms_state_t st,
                                           input logic [15:0] mem_q);
    logic [15:0] rd;
    rd = 16'h0000;
    if (hits(dev, adr, pms_pkg::DEV_VENDOR, pms_pkg::REG_BASIC_CTRL)) begin
      rd = {st.rst_busy, st.loopback, pms_pkg::CTRL_SPEED_VAL, // RL14
            pms_pkg::CTRL_ANEG_VAL, st.pd, st.iso,
            pms_pkg::CTRL_RSVD}; // RL22
    end else if (hits(dev, adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_BASIC_STAT)) begin
      rd = pms_pkg::STAT_FIXED |
           {11'h000, st.rf_lh, 1'h0, st.link_ll, st.jab_lh, 1'h0};
    end else if (hits(dev, adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_EXT_CTRL)) begin
      rd = st.ext_ctrl;
    end else if (hits(dev, adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_EXT_DATA)) begin
      rd = st.ext_addr;
    end else if (hits(dev, adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_STRAP_STAT)) begin
      rd = {8'h00, st.led_pol, st.auto_strap, st.phy_addr}; // RL19
    end else if (hits(dev, adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_LINK_CTRL)) begin
      rd = {15'h0000, st.link_start};
    end else if (hits(dev, adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_LED_SEL)) begin
      rd = st.led_sel; // RL6
    end else if (dev == pms_pkg::DEV_PMA && adr[15:4] == 12'h000) begin
      rd = mem_q; // RL10
    end
    return rd;
  endfunction : read_reg

  // ==========================================================
  // Next state
  always_comb begin
    logic edge_r;
    logic bin;
    logic ext_data;
    logic rd_hit;
    logic wr_en;
    logic clear_on_read;
    logic inc;
    logic led_on;
    logic [4:0] tgt_dev;
    logic [15:0] tgt_adr;
    logic [15:0] rdv;
    logic [15:0] wv;
    edge_r = s.mdc_s2 & ~s.mdc_s3;
    bin = s.mdio_s2;
    // Data register with a data function steers to the window target
    ext_data = (s.regad == pms_pkg::REG_EXT_DATA[4:0]) &&
               (s.ext_ctrl[pms_pkg::EXT_FN_MSB -: 2] !=
                pms_pkg::EXT_FN_ADDR); // RL9
    // Five bit register field cannot name anything above 0x1f
    tgt_dev = ext_data ? s.ext_ctrl[4:0] : pms_pkg::DEV_VENDOR; // RL7 RL8
    tgt_adr = ext_data ? s.ext_addr : {11'h000, s.regad}; // RL11
    rdv = read_reg(tgt_dev, tgt_adr, s, mem_bus.rdata);
    wv = {s.sh[14:0], bin};
    rd_hit = s.hit && (s.op == pms_pkg::OP_RD);
    wr_en = 1'h0;
    clear_on_read = 1'h0;
    inc = 1'h0;
    led_on = 1'h0;
    next_s = s;
    next_s.mem_we = 1'h0;

    // Pin synchronisers, two stages each; the management clock gets a third for edge detection
    next_s.mdc_s1 = mdc;
    next_s.mdc_s2 = s.mdc_s1;
    next_s.mdc_s3 = s.mdc_s2;
    next_s.mdio_s1 = mdio_in;
    next_s.mdio_s2 = s.mdio_s1;
    next_s.pd_s1 = irq_or_powerdown_pin_n;
    next_s.pd_s2 = s.pd_s1;
    next_s.led_s1 = {indicator_c_in, indicator_b_in, indicator_a_in};
    next_s.led_s2 = s.led_s1;
    next_s.adr_s1 = mgmt_addr_strap;
    next_s.adr_s2 = s.adr_s1;

    // Strap capture once the synchronisers hold real pin levels
    if (!s.strap_done) begin
      if (s.strap_cnt == pms_pkg::STRAP_SETTLE) begin
        next_s.strap_done = 1'h1; // RL2
        next_s.phy_addr = s.adr_s2; // RL1 RL3
        next_s.auto_strap = s.led_s2[1]; // RL4
        next_s.led_pol = s.led_s2; // RL5
      end else begin
        next_s.strap_cnt = s.strap_cnt + 2'h1;
      end
    end

    // Management frame receiver, advanced on each rising clock edge
    if (edge_r) begin
      next_s.cnt = s.cnt + 5'h01;
      next_s.sh = wv;
      case (s.st)
        pms_pkg::MS_IDLE: begin
          next_s.cnt = 5'h00;
          if (!bin) begin
            next_s.st = pms_pkg::MS_START;
          end
        end
        pms_pkg::MS_START: begin
          next_s.cnt = 5'h00;
          next_s.st = bin ? pms_pkg::MS_OP : pms_pkg::MS_IDLE;
        end
        pms_pkg::MS_OP: begin
          if (s.cnt == 5'h01) begin
            next_s.op = wv[1:0];
            next_s.cnt = 5'h00;
            next_s.st = pms_pkg::MS_PHY;
          end
        end
        pms_pkg::MS_PHY: begin
          if (s.cnt == 5'h04) begin
            next_s.hit = s.strap_done && (wv[4:0] == {1'h0, s.phy_addr}) &&
                         (s.op == pms_pkg::OP_RD ||
                          s.op == pms_pkg::OP_WR); // RL21
            next_s.cnt = 5'h00;
            next_s.st = pms_pkg::MS_REG;
          end
        end
        pms_pkg::MS_REG: begin
          if (s.cnt == 5'h04) begin
            next_s.regad = wv[4:0];
            next_s.mem_raddr = s.ext_addr[3:0];
            next_s.cnt = 5'h00;
            next_s.st = pms_pkg::MS_TA;
          end
        end
        pms_pkg::MS_TA: begin
          if (s.cnt == 5'h00) begin
            next_s.mdio_oe = rd_hit;
            next_s.mdio_out = 1'h0;
          end else begin
            next_s.cnt = 5'h00;
            next_s.st = pms_pkg::MS_DATA;
            if (rd_hit) begin
              next_s.sh = rdv;
              next_s.mdio_out = rdv[15];
              clear_on_read = hits(tgt_dev, tgt_adr, pms_pkg::DEV_VENDOR,
                         pms_pkg::REG_BASIC_STAT); // RL17
              inc = ext_data & s.ext_ctrl[pms_pkg::EXT_FN_MSB];
            end
          end
        end
        default: begin
          next_s.mdio_out = s.sh[14];
          if (s.cnt == 5'h0f) begin
            next_s.st = pms_pkg::MS_IDLE;
            next_s.mdio_oe = 1'h0;
            next_s.mdio_out = 1'h0;
            if (s.hit && s.op == pms_pkg::OP_WR) begin
              if (s.regad == pms_pkg::REG_EXT_CTRL[4:0]) begin
                next_s.ext_ctrl = wv; // RL9
              end else if (s.regad == pms_pkg::REG_EXT_DATA[4:0] &&
                           !ext_data) begin
                next_s.ext_addr = wv; // RL9
              end else begin
                wr_en = 1'h1;
                inc = ext_data & s.ext_ctrl[pms_pkg::EXT_FN_MSB];
              end
            end
          end
        end
      endcase
    end
    if (inc) begin
      next_s.ext_addr = s.ext_addr + 16'h0001;
    end

    // Latched status: a new event beats the clear of a read
    next_s.rf_lh = (s.rf_lh & ~clear_on_read) | remote_fault; // RL17
    next_s.jab_lh = (s.jab_lh & ~clear_on_read) | jabber; // RL17
    next_s.link_ll = (s.link_ll | clear_on_read) & s.link_ind; // RL17

    // Soft reset timer; the bit reads one only while it runs
    if (s.rst_busy) begin
      if (s.rst_cnt == 8'h00) begin
        next_s.rst_busy = 1'h0; // RL12 RL18
      end else begin
        next_s.rst_cnt = s.rst_cnt - 8'h01;
      end
    end

    // Register writes, reserved and read-only bits simply dropped
    if (wr_en && hits(tgt_dev, tgt_adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_BASIC_CTRL)) begin
      next_s.loopback = wv[pms_pkg::CTRL_LOOP]; // RL13
      next_s.pd = wv[pms_pkg::CTRL_PD]; // RL15
      next_s.iso = wv[pms_pkg::CTRL_ISO]; // RL16
      if (wv[pms_pkg::CTRL_RST] && !s.rst_busy) begin
        // Coding sublayer controls go back to defaults, vendor ones stay
        next_s.rst_busy = 1'h1; // RL12
        next_s.rst_cnt = pms_pkg::SOFT_RST_LOAD;
        next_s.loopback = 1'h0;
        next_s.pd = 1'h0;
        next_s.iso = 1'h0;
      end
    end
    if (wr_en && hits(tgt_dev, tgt_adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_LINK_CTRL)) begin
      next_s.link_start = wv[0]; // RL4
    end
    if (wr_en && hits(tgt_dev, tgt_adr, pms_pkg::DEV_VENDOR,
                      pms_pkg::REG_LED_SEL)) begin
      next_s.led_sel = wv; // RL6
    end
    if (wr_en && tgt_dev == pms_pkg::DEV_PMA &&
        tgt_adr[15:4] == 12'h000) begin
      next_s.mem_we = 1'h1; // RL10
      next_s.mem_waddr = tgt_adr[3:0];
      next_s.mem_wdata = wv;
    end

    // Pin power down forces the bit, winning over a software clear
    if (!s.pd_s2) begin
      next_s.pd = 1'h1; // RL15
    end

    // Link status and link start gating
    next_s.link_ind = link_up & ~s.loopback; // RL13
    next_s.link_en = s.strap_done & (~s.auto_strap | s.link_start) &
                     ~s.pd & ~s.rst_busy; // RL4

    // LED functions; polarity from the strap avoids fighting the resistor
    next_s.clk_div = ~s.clk_div;
    for (int i = 0; i < 3; i++) begin
      case (s.led_sel[i * pms_pkg::LED_STRIDE +: 2])
        pms_pkg::LED_FN_LINK: led_on = s.link_ind;
        pms_pkg::LED_FN_ACT: led_on = activity;
        pms_pkg::LED_FN_ON: led_on = 1'h1;
        default: led_on = 1'h0;
      endcase
      next_s.led_out[i] = led_on ^ s.led_pol[i]; // RL5
    end
    if (s.led_sel[pms_pkg::LED_CLK_SEL]) begin
      next_s.led_out[2] = s.clk_div; // RL6
    end
  end

  // ==========================================================
  // Registers; pin-level power down idles high through reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.pd_s1 <= 1'h1;
      s.pd_s2 <= 1'h1;
      s.led_sel <= pms_pkg::LED_SEL_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign mdio_out = s.mdio_out;
  assign mdio_oe = s.mdio_oe;
  assign indicator_out_a = s.led_out[0];
  assign indicator_out_b = s.led_out[1];
  assign indicator_out_c = s.led_out[2];
  // Pins stay inputs until the straps are captured
  assign indicator_a_oe = s.strap_done;
  assign indicator_b_oe = s.strap_done;
  assign indicator_c_oe = s.strap_done;
  assign pcs_reset = s.rst_busy;
  assign mac_loopback = s.loopback;
  assign power_down = s.pd;
  assign isolate = s.iso;
  assign link_enable = s.link_en;
  assign link_indication = s.link_ind;
endmodule : pms_top

// ==== pms_properties.sv ====
// Port-level checks for the management strap and control block
module pms_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic irq_or_powerdown_pin_n,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic indicator_a_oe,
  input wire logic indicator_b_oe,
  input wire logic indicator_c_oe,
  input wire logic pcs_reset,
  input wire logic mac_loopback,
  input wire logic power_down,
  input wire logic isolate,
  input wire logic link_enable,
  input wire logic link_indication
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Helper
  logic [7:0] hi_cnt;

  // Length of the running soft reset, zero when idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= pcs_reset ? hi_cnt + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Assertions
  AST_LOOP_NO_LINK: assert property (mac_loopback |=> !link_indication)
    else $error("link indicated during loopback");
  AST_PD_PIN: assert property (
    (!irq_or_powerdown_pin_n) [*5] |-> power_down)
    else $error("power-down pin did not set power down");
  AST_PD_NO_LINK: assert property (
    power_down && $past(power_down) |-> !link_enable)
    else $error("link enabled while powered down");
  AST_RST_LEN: assert property (
    $fell(pcs_reset) |-> hi_cnt == 8'(pms_pkg::SOFT_RST_CYC))
    else $error("soft reset length wrong");
  AST_RST_CLEARS: assert property (
    pcs_reset && $past(pcs_reset) |->
    !mac_loopback && !isolate && !link_enable)
    else $error("control bits survive soft reset");
  AST_OE_HOLD: assert property (
    indicator_a_oe |=>
    $stable({indicator_a_oe, indicator_b_oe, indicator_c_oe}))
    else $error("strap capture changed after latching");
  AST_TA_LOW: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not driven low");
  AST_LINKEN_STRAP: assert property (link_enable |-> indicator_b_oe)
    else $error("link enabled before straps latched");

  // Main scenarios reached
  cover property ($rose(pcs_reset));
  cover property ($rose(mdio_oe));
  cover property ($rose(power_down));
endmodule : pms_properties

// ==== pms_smi_master.sv ====
// Station management controller model on the serial management bus
module pms_smi_master (
  input wire logic clk,
  input wire logic mdio_wire,
  output logic mdc,
  output logic md_drv,
  output logic rd_valid,
  output logic [16:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int hp = 4; // Half period in clk cycles, never under 4

  // Clock stands low and data rests at the pull-up level between frames
  initial begin
    mdc = 1'b0;
    md_drv = 1'b1;
    rd_valid = 1'b0;
    rd_data = 17'h00000;
  end

  // ==========================================================
  // One frame; one fixed address on the bus, so no clash
  // Register field is five bits, direct frames stay below 0x20
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] rg, input logic [15:0] wd);
    logic [33:0] bits;
    logic [16:0] q;
    bits = {4'hd, op, pa, rg, 2'h2, wd};
    q = 17'h00000;
    for (int i = 0; i < 34; i++) begin
      @(negedge clk);
      mdc = 1'b0;
      md_drv = (op == pms_pkg::OP_RD && i > 15) ? 1'b1 : bits[33 - i];
      repeat (hp) @(negedge clk);
      mdc = 1'b1;
      q = (i > 16) ? {q[15:0], mdio_wire} : q; // Second turnaround bit, data
      repeat (hp - 1) @(negedge clk);
    end
    @(negedge clk);
    mdc = 1'b0;
    md_drv = 1'b1;
    if (op == pms_pkg::OP_RD) begin
      rd_data = q;
      rd_valid = 1'b1;
      @(negedge clk);
      rd_valid = 1'b0;
    end
  endtask : frame
endmodule : pms_smi_master

// ==== testbench.sv ====
// Self-checking bench for the management strap and control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n, ce, mdc, mdio_in, mdio_out, mdio_oe, md_drv, rd_valid;
  logic irq_or_powerdown_pin_n, link_up, activity, jabber, remote_fault;
  logic indicator_a_in, indicator_out_a, indicator_a_oe;
  logic indicator_b_in, indicator_out_b, indicator_b_oe;
  logic indicator_c_in, indicator_out_c, indicator_c_oe;
  logic pcs_reset, mac_loopback, power_down, isolate, link_enable;
  logic link_indication, strap_a, strap_b, strap_c, held;
  logic [3:0] mgmt_addr_strap;
  logic [16:0] rd_data;
  logic [16:0] exq[$];
  logic [16:0] mkq[$];
  logic [15:0] seed = 16'h72d1;
  logic [4:0] phy;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int rst_len = 0;
  localparam logic [16:0] ALL = 17'h1ffff;

  always #2.5 clk = ~clk;

  // Pin levels: driver wins, else pull-up or strap resistor
  assign mdio_in = mdio_oe ? mdio_out : md_drv;
  assign indicator_a_in = indicator_a_oe ? indicator_out_a : strap_a;
  assign indicator_b_in = indicator_b_oe ? indicator_out_b : strap_b;
  assign indicator_c_in = indicator_c_oe ? indicator_out_c : strap_c;

  pms_top DUT (
    .clk, .reset_n, .ce, .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .mgmt_addr_strap, .irq_or_powerdown_pin_n, .link_up, .activity,
    .jabber, .remote_fault, .indicator_a_in, .indicator_out_a,
    .indicator_a_oe, .indicator_b_in, .indicator_out_b, .indicator_b_oe,
    .indicator_c_in, .indicator_out_c, .indicator_c_oe, .pcs_reset,
    .mac_loopback, .power_down, .isolate, .link_enable, .link_indication
  );
  pms_smi_master u_smi (
    .clk, .mdio_wire(mdio_in), .mdc, .md_drv, .rd_valid, .rd_data
  );

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // Note the answer first; the monitor compares when it arrives
  task automatic rd(input logic [4:0] pa, input logic [4:0] rg,
                    input logic [16:0] e, input logic [16:0] m);
    exq.push_back(e & m);
    mkq.push_back(m);
    u_smi.frame(pms_pkg::OP_RD, pa, rg, 16'h0000);
  endtask : rd

  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    u_smi.frame(pms_pkg::OP_WR, phy, rg, d);
  endtask : wr

  // Window set-up: device, target, then data without increment
  task automatic win(input logic [4:0] dev, input logic [15:0] adr);
    wr(5'h0d, {11'h000, dev});
    wr(5'h0e, adr);
    wr(5'h0d, {11'h200, dev});
  endtask : win

  // Read answers against the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && exq.size() > 0) begin
      check(rd_data & mkq.pop_front(), exq.pop_front());
    end
  end

  // Hang guard and soft reset length count
  always @(negedge clk) begin
    cycles++;
    rst_len = (pcs_reset === 1'b1) ? rst_len + 1 : rst_len;
    if (cycles == 60000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    irq_or_powerdown_pin_n = 1'b1;
    link_up = 1'b1;
    activity = 1'b0;
    jabber = 1'b0;
    remote_fault = 1'b0;
    {strap_a, strap_b, strap_c} = 3'h6;
    seed = lfsr(seed);
    mgmt_addr_strap = seed[3:0];
    phy = {1'b0, seed[3:0]};
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    check(17'(link_enable), 17'h00000);
    rd(phy, 5'h00, 17'h02100, ALL);
    rd(phy, 5'h10, {9'h000, strap_c, strap_b, strap_a, strap_b, phy[3:0]},
       ALL);
    rd({1'b0, phy[3:0] ^ 4'h1}, 5'h00, ALL, ALL);
    rd({1'b1, phy[3:0]}, 5'h00, ALL, ALL);
    wr(5'h11, 16'h0001);
    repeat (10) @(negedge clk);
    check(17'(link_enable), 17'h00001);
    // Random status levels against strapped polarity
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      activity = seed[0];
      link_up = seed[1];
      repeat (10) @(negedge clk);
      check(17'(indicator_out_b), 17'(activity ^ strap_b));
      check(17'(indicator_out_a), 17'(link_up ^ strap_a));
    end
    link_up = 1'b1;
    wr(5'h00, 16'h5fff);
    rd(phy, 5'h00, 17'h06d00, ALL);
    check(17'({mac_loopback, power_down, isolate}), 17'h7);
    check(17'({link_indication, link_enable}), 17'h0);
    win(5'h1f, pms_pkg::REG_LED_SEL);
    wr(5'h0e, 16'h0013);
    rst_len = 0;
    wr(5'h00, 16'h8000);
    repeat (10) @(negedge clk);
    for (int i = 0; i < 400 && pcs_reset !== 1'b0; i++) @(negedge clk);
    check(17'(rst_len), 17'(pms_pkg::SOFT_RST_CYC));
    rd(phy, 5'h00, 17'h02100, ALL);
    check(17'(indicator_out_a), 17'(strap_a));
    win(5'h1f, pms_pkg::REG_LED_SEL);
    rd(phy, 5'h0e, 17'h00013, ALL);
    win(5'h1f, 16'h0000);
    rd(phy, 5'h0e, 17'h02100, ALL);
    // Second space with a slow controller
    u_smi.hp = 9;
    seed = lfsr(seed);
    win(5'h01, 16'h0003);
    wr(5'h0e, seed);
    win(5'h01, 16'h0003);
    rd(phy, 5'h0e, {1'b0, seed}, ALL);
    u_smi.hp = 4;
    // Post increment: second read must land on the next, untouched word
    wr(5'h0d, 16'h8001);
    rd(phy, 5'h0e, {1'b0, seed}, ALL);
    rd(phy, 5'h0e, 17'h00000, ALL);
    irq_or_powerdown_pin_n = 1'b0;
    repeat (10) @(negedge clk);
    check(17'(power_down), 17'h00001);
    rd(phy, 5'h00, 17'h02900, ALL);
    irq_or_powerdown_pin_n = 1'b1;
    wr(5'h00, 16'h0000);
    jabber = 1'b1;
    remote_fault = 1'b1;
    @(negedge clk);
    jabber = 1'b0;
    remote_fault = 1'b0;
    rd(phy, 5'h01, 17'h00073, 17'h1fffb);
    rd(phy, 5'h01, 17'h00061, 17'h1fffb);
    // Hardware reset with no pull-ups, then straps moved
    {strap_a, strap_b, strap_c} = 3'h0;
    mgmt_addr_strap = 4'h0;
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    mgmt_addr_strap = 4'h5;
    phy = 5'h00;
    check(17'(link_enable), 17'h00001);
    check(17'(indicator_out_b), 17'(activity));
    rd(5'h00, 5'h00, 17'h02100, ALL);
    rd(5'h05, 5'h00, ALL, ALL);
    // Pin c forced on, then clock output, then frozen by the enable
    win(5'h1f, pms_pkg::REG_LED_SEL);
    wr(5'h0e, 16'h0200);
    repeat (4) @(negedge clk);
    check(17'(indicator_out_c), 17'h00001);
    wr(5'h0e, 16'h1000);
    repeat (4) @(negedge clk);
    held = indicator_out_c;
    @(negedge clk);
    check(17'(indicator_out_c), 17'(!held));
    ce = 1'b0;
    held = indicator_out_c;
    repeat (3) @(negedge clk);
    check(17'(indicator_out_c), 17'(held));
    ce = 1'b1;
    repeat (10) @(negedge clk);
    check(17'(exq.size()), 17'h00000);
    print_verdict();
  end
endmodule : testbench

bind pms_top pms_properties u_props (
  .clk, .reset_n, .irq_or_powerdown_pin_n, .mdio_out, .mdio_oe,
  .indicator_a_oe, .indicator_b_oe, .indicator_c_oe, .pcs_reset,
  .mac_loopback, .power_down, .isolate, .link_enable, .link_indication
);
